// ---- verilog/lbha_arbiter.sv ----
// Local bus hold arbiter: hold handshake, bus float control and bus cycle ranking.
//
// Functional notes
// - Grant stays asserted as long as hold request stays active, normally.
// - Control, status, upper address and lock float one clock before grant.
// - Address/data lines and data enable float in the clock grant rises.
// - Idle bus: grant follows hold request after two clocks, the minimum latency.
// - No grant while the current cycle waits on not-ready.
// - No grant while the bus lock output is asserted.
// - Grant only after current cycle; never split an odd-aligned word pair.
// - Interrupt acknowledge cycles assert bus lock; grant waits until they finish.
// - Grant waits for DMA or refresh; DMA transfers of up to four cycles stay whole.
// - Refresh outranks hold; simultaneous requests run refresh first.
// - Refresh during hold drops grant; bus retaken only after request removal.
// - Request reasserted before refresh finishes gets the bus granted again afterwards.
// - Leaving hold with nothing pending keeps the bus floating unless idle or powerdown.
// - Eleven request sources ranked from non-pipelined execution down to prefetch.
// - Exchange and string cycles may be interleaved with other cycles.
// - Locked instruction cycles run unseparated by hold, DMA or refresh until the instruction ends.
// - Hold, DMA and refresh wait during a lock; interrupts are unaffected.
`timescale 1ns/1ps
`default_nettype none
`include "lbha_consts.svh"

module lbha_arbiter (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic                      holdRequest,
  input  wire logic [`LBHA_NSRC-1:0]     cycleReq,
  input  wire lbha_pkg::lbha_cyc_status_t cycStatus,
  input  wire logic                      lockedInstr,
  input  wire logic                      idleOrPowerdown,
  output var  logic                      busGrantOut,
  output var  lbha_pkg::lbha_float_t     busFloat,
  output var  logic                      busLock,
  output var  logic                      interruptAckCycle,
  output var  logic [`LBHA_NSRC-1:0]     cycleGrant
);

  import lbha_pkg::*;

  lbha_state_t           state;
  logic                  holdSync;
  logic                  cycleActive;
  logic                  chainPending;
  logic [2:0]            chainCnt;
  logic [3:0]            curSrc;
  logic [`LBHA_NSRC-1:0] eligible;
  logic [3:0]            winner;
  logic                  anyReq;
  logic                  busFree;
  logic                  holdPick;
  logic                  issue;
  logic                  cycleDone;
  logic                  refreshNeed;
  logic [2:0]            chainMax;

  // ============================================================
  // Input synchronisation.
  // The pin comes from another master's clock, so two flops guard it.
  lbha_sync u_hold_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .asyncIn (holdRequest),
    .syncOut (holdSync)
  );

  // ============================================================
  // Request masking and ranking.
  // A lock or an unfinished chain narrows who may compete for the bus.
  always_comb begin
    eligible                 = cycleReq;
    eligible[`LBHA_SRC_HOLD] = holdSync;
    if (lockedInstr || busLock) begin
      eligible[`LBHA_SRC_REFRESH_STROBE] = 1'b0;
      eligible[`LBHA_SRC_HOLD] = 1'b0;
      eligible[`LBHA_SRC_DMA]  = 1'b0;
    end
    if (chainPending) begin
      eligible = '0;
      eligible[curSrc] = cycleReq[curSrc];
    end
  end

  // Lowest index wins; exchange and string cycles are not chained, so others may cut in.
  always_comb begin
    winner = 4'h0;
    anyReq = 1'b0;
    for (int i = `LBHA_NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        winner = i[3:0];
        anyReq = 1'b1;
      end
    end
  end

  // The bus is free once no cycle runs; a not-ready cycle keeps it busy.
  assign cycleDone   = cycleActive && cycStatus.cycleEnd && cycStatus.busReady;
  assign busFree     = (state == ST_OWN) && !cycleActive;
  assign holdPick    = busFree && anyReq && (winner == `LBHA_SRC_HOLD);
  assign issue       = busFree && anyReq && (winner != `LBHA_SRC_HOLD);
  assign refreshNeed = cycleReq[`LBHA_SRC_REFRESH_STROBE] && !lockedInstr;
  assign chainMax    = (curSrc == `LBHA_SRC_DMA) ? `LBHA_DMA_CHAIN_MAX : `LBHA_ODD_CHAIN_MAX;

  // ============================================================
  // Hold handshake state machine.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_OWN;
    end else begin
      unique case (state)
        ST_OWN: begin
          if (holdPick) begin
            state <= ST_FLOAT;
          end
        end
        ST_FLOAT: begin
          state <= ST_HELD;
        end
        ST_HELD: begin
          if (!holdSync) begin
            state <= ST_OWN;
          end else if (refreshNeed) begin
            state <= ST_RFWAIT;
          end
        end
        ST_RFWAIT: begin
          if (!holdSync) begin
            state <= ST_OWN;
          end
        end
      endcase
    end
  end

  // Grant output; it can be a one-clock pulse when refresh arrives right after.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busGrantOut <= 1'b0;
    end else begin
      busGrantOut <= (state == ST_FLOAT) ||
                     ((state == ST_HELD) && holdSync && !refreshNeed);
    end
  end

  // ============================================================
  // Bus float control.
  // Floats persist after hold until a cycle starts or the bus is owned while idle or powerdown, to avoid driving a bus nobody needs.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busFloat <= '0;
    end else if (holdPick) begin
      busFloat.floatCtrl <= 1'b1;
    end else if (state == ST_FLOAT) begin
      busFloat.floatAddrData <= 1'b1;
    end else if (issue || (state == ST_OWN && idleOrPowerdown)) begin
      busFloat <= '0;
    end
  end

  // ============================================================
  // Bus cycle issue and tracking.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cycleGrant  <= '0;
      cycleActive <= 1'b0;
      curSrc      <= 4'h0;
    end else begin
      cycleGrant <= '0;
      if (issue) begin
        cycleGrant[winner] <= 1'b1;
        cycleActive        <= 1'b1;
        curSrc             <= winner;
      end else if (cycleDone) begin
        cycleActive <= 1'b0;
      end
    end
  end

  // Chain tracking keeps odd words and DMA transfers whole, bounded by the chain limit.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      chainPending <= 1'b0;
      chainCnt     <= 3'h0;
    end else if (cycleDone) begin
      if (cycStatus.chained && (chainCnt + 3'h2 <= chainMax)) begin
        chainPending <= 1'b1;
        chainCnt     <= chainCnt + 3'h1;
      end else begin
        chainPending <= 1'b0;
        chainCnt     <= 3'h0;
      end
    end else if (issue) begin
      chainPending <= 1'b0;
    end else if (chainPending && !cycleReq[curSrc]) begin
      // A requester that withdraws mid-chain would otherwise lock out every other source.
      chainPending <= 1'b0;
      chainCnt     <= 3'h0;
    end
  end

  // ============================================================
  // Lock and interrupt acknowledge outputs.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      busLock           <= 1'b0;
      interruptAckCycle <= 1'b0;
    end else begin
      interruptAckCycle <= (issue && winner == `LBHA_SRC_HWINT) ||
                           (interruptAckCycle && !cycleDone);
      busLock <= lockedInstr || (issue && winner == `LBHA_SRC_HWINT) ||
                 (interruptAckCycle && !cycleDone);
    end
  end

  // ============================================================
  // Assertions.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_float_before_grant: assert property ($rose(busGrantOut) |-> $past(busFloat.floatCtrl) && busFloat.floatCtrl)
    else $error("grant rose without control floated a clock earlier");
  // Floats may linger from an earlier hold, so only a fresh address/data float is tied to the grant edge.
  a_addr_float_grant: assert property ($rose(busFloat.floatAddrData) |-> $rose(busGrantOut) && busFloat.floatCtrl)
    else $error("address data floated apart from the grant edge");
  a_grant_bus_float: assert property (busGrantOut |-> busFloat.floatAddrData && busFloat.floatCtrl)
    else $error("grant shown while the bus is still driven");
  a_grant_kept: assert property (busGrantOut && state == ST_HELD && holdSync && !refreshNeed |=> busGrantOut)
    else $error("grant dropped while hold request stayed");
  a_min_latency: assert property (holdPick |=> busFloat.floatCtrl ##1 busGrantOut)
    else $error("idle bus grant not two clocks after request");
  a_no_grant_busy: assert property ($rose(state == ST_FLOAT) |-> $past(!cycleActive && !chainPending))
    else $error("hold taken during a busy or chained cycle");
  a_no_grant_lock: assert property ($rose(state == ST_FLOAT) |-> $past(!busLock && !lockedInstr))
    else $error("hold taken while lock active");
  a_ack_cycle_lock: assert property (interruptAckCycle |-> busLock)
    else $error("interrupt acknowledge cycle without lock");
  a_refresh_drop: assert property (state == ST_HELD && holdSync && refreshNeed |=>
                                   !busGrantOut ##1 (state != ST_OWN || !holdSync))
    else $error("grant not dropped for refresh");
  a_rfwait_no_grant: assert property (state == ST_RFWAIT |-> !busGrantOut)
    else $error("grant shown while waiting to refresh");
  a_grant_release: assert property (state == ST_HELD && !holdSync |=> !busGrantOut && state == ST_OWN)
    else $error("grant kept after the hold request fell");

  // Cycle starts come one at a time and never while the bus is lent out.
  a_grant_onehot: assert property ($onehot0(cycleGrant))
    else $error("more than one bus cycle started at once");
  a_no_cycle_held: assert property (state != ST_OWN |-> cycleGrant == '0)
    else $error("bus cycle started while the bus was lent out");
  a_lock_masks: assert property (lockedInstr |=> !cycleGrant[`LBHA_SRC_DMA] && !cycleGrant[`LBHA_SRC_REFRESH_STROBE])
    else $error("refresh or transfer cycle started inside a locked instruction");
  a_refresh_first: assert property (busFree && !chainPending && !lockedInstr && !busLock && holdSync &&
                                    cycleReq[`LBHA_SRC_REFRESH_STROBE] && !cycleReq[`LBHA_SRC_EXEC_NP]
                                    |=> cycleGrant[`LBHA_SRC_REFRESH_STROBE])
    else $error("refresh not run before hold");
  a_float_stays: assert property (busFloat.floatCtrl && !issue && !idleOrPowerdown |=> busFloat.floatCtrl)
    else $error("bus float released with nothing pending");

  c_hold_grant: cover property (holdPick ##2 busGrantOut);
  c_refresh_in_hold: cover property (busGrantOut ##1 state == ST_RFWAIT);
  c_dma_chain: cover property (chainPending && curSrc == `LBHA_SRC_DMA && chainCnt == 3'h3);
  c_locked_hold: cover property (lockedInstr && holdSync ##1 !lockedInstr);
  c_ack_cycle: cover property ($rose(interruptAckCycle));

endmodule : lbha_arbiter

`default_nettype wire

// ---- verilog/lbha_consts.svh ----
// Constants for the local bus hold arbiter: request ranks, chain limits, latency.
`ifndef LBHA_CONSTS_SVH
`define LBHA_CONSTS_SVH

// ============================================================
// Request ranks, index 0 is the highest priority.
`define LBHA_NSRC         11
`define LBHA_SRC_EXEC_NP  4'h0
`define LBHA_SRC_REFRESH_STROBE     4'h1
`define LBHA_SRC_HOLD     4'h2
`define LBHA_SRC_STEP     4'h3
`define LBHA_SRC_NMI      4'h4
`define LBHA_SRC_IERR     4'h5
`define LBHA_SRC_HWINT    4'h6
`define LBHA_SRC_CPERR    4'h7
`define LBHA_SRC_DMA      4'h8
`define LBHA_SRC_EXEC     4'h9
`define LBHA_SRC_PREF     4'hA

// ============================================================
// Inseparable chains: a DMA transfer runs up to four cycles, an odd word two.
`define LBHA_DMA_CHAIN_MAX 3'h4
`define LBHA_ODD_CHAIN_MAX 3'h2

// Shortest hold latency in processor clocks, counted from the synchronised request.
`define LBHA_HOLD_LAT_CLK  2

`endif

// ---- verilog/lbha_pkg.sv ----
// Types shared by the local bus hold arbiter files.
`default_nettype none

package lbha_pkg;

  // Arbiter states, one-hot.
  typedef enum logic [3:0] {
    ST_OWN    = 4'b0001,
    ST_FLOAT  = 4'b0010,
    ST_HELD   = 4'b0100,
    ST_RFWAIT = 4'b1000
  } lbha_state_t;

  // Status of the running bus cycle, from the bus sequencer.
  typedef struct packed {
    logic cycleEnd;
    logic busReady;
    logic chained;
  } lbha_cyc_status_t;

  // Float controls for the local bus pins.
  typedef struct packed {
    logic floatCtrl;
    logic floatAddrData;
  } lbha_float_t;

endpackage : lbha_pkg

`default_nettype wire

// ---- verilog/lbha_sync.sv ----
// Two flip-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
`default_nettype none

module lbha_sync (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  logic stage1;

  // ============================================================
  // Only the second flop reads the first, so metastability settles there.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1  <= 1'b0;
      syncOut <= 1'b0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule : lbha_sync

`default_nettype wire

// ---- bench/lbha_ext_master.sv ----
// Behavioural external bus master that borrows the local bus through the hold handshake.
`timescale 1ns/1ps
`default_nettype none

module lbha_ext_master (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic want,
  input  wire logic busGrantOut,
  output var  logic holdRequest,
  output var  logic owns
);
  logic [1:0] rest;

  // ============================================================
  // Requester. The grant is latched, since it may last one clock only and a missed pulse hangs the bus.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      holdRequest <= 1'b0;
      owns        <= 1'b0;
      rest        <= 2'h0;
    end else if (rest != 2'h0) begin
      rest <= rest - 2'h1;
    end else if (!holdRequest && want) begin
      holdRequest <= 1'b1;
    end else if (holdRequest && owns && (!want || !busGrantOut)) begin
      holdRequest <= 1'b0;
      owns        <= 1'b0;
      rest        <= 2'h2;
    end else if (holdRequest && busGrantOut) begin
      owns <= 1'b1;
    end
  end
endmodule : lbha_ext_master

`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the local bus hold arbiter.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nCompared++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module testbench;
  import lbha_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic want = 1'b0;
  logic holdRequest, owns, busGrantOut, busLock, interruptAckCycle;
  logic lockedInstr = 1'b0;
  logic idleOrPowerdown = 1'b0;
  logic [10:0] cycleReq = 11'h000;
  logic [10:0] cycleGrant;
  logic [10:0] got;
  lbha_cyc_status_t cycStatus = 3'b000;
  lbha_float_t busFloat;
  logic [31:0] lfsr = 32'h41f5_320f;
  int miscompares = 0;
  int nCompared = 0;

  lbha_ext_master partner (.clk_sys(clk_sys), .reset(reset), .want(want), .busGrantOut(busGrantOut),
    .holdRequest(holdRequest), .owns(owns));
  lbha_arbiter dut (.clk_sys(clk_sys), .reset(reset), .holdRequest(holdRequest), .cycleReq(cycleReq),
    .cycStatus(cycStatus), .lockedInstr(lockedInstr), .idleOrPowerdown(idleOrPowerdown),
    .busGrantOut(busGrantOut), .busFloat(busFloat), .busLock(busLock),
    .interruptAckCycle(interruptAckCycle), .cycleGrant(cycleGrant));

  // ============================================================
  // Clock at 25 MHz.
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  // Steps n clocks, one by default; inputs then change and outputs are settled.
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge clk_sys);
      #1;
    end
  endtask : tick

  // Highest ranked source among the requests; index 2 belongs to the hold pin.
  function automatic logic [10:0] winner(input logic [10:0] r);
    for (int i = 0; i < 11; i++) begin
      if (r[i] && i != 2) return 11'h001 << i;
    end
    return 11'h000;
  endfunction : winner

  // Next value of the stimulus shift register.
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand

  // Waits, bounded, until the grant output reaches the given level.
  task automatic waitGrant(input logic lvl, input int lim);
    for (int i = 0; i < lim && busGrantOut !== lvl; i++) tick();
  endtask : waitGrant

  // Requests cycles, returns the issued grant and withdraws the request.
  task automatic issue(input logic [10:0] req);
    cycleReq <= req;
    got = 11'h000;
    for (int i = 0; i < 20 && got === 11'h000; i++) begin
      tick();
      if (cycleGrant !== 11'h000) got = cycleGrant;
    end
    cycleReq <= 11'h000;
  endtask : issue

  // Ends the running cycle with a ready completion.
  task automatic finish();
    cycStatus <= 3'b110;
    tick();
    cycStatus <= 3'b000;
    tick();
  endtask : finish

  task automatic completeRun();
    $display("compared %0d, mismatches %0d", nCompared, miscompares);
    if (miscompares == 0 && nCompared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : completeRun

  // ============================================================
  // Watchdog, far beyond the few hundred clocks that the tests need.
  initial begin
    #(40 * 20000);
    miscompares++;
    completeRun();
  end

  // ============================================================
  // Main sequence.
  initial begin
    tick(16);
    reset <= 1'b0;
    tick(2);
    // Ranking of random request sets; the interrupt source also shows lock.
    for (int k = 0; k < 24; k++) begin
      lfsr = nextRand(lfsr);
      if (k == 0) lfsr[10:0] = 11'h040;
      if (k == 1) lfsr[10:0] = 11'h600;
      issue(lfsr[10:0] | 11'h400);
      `CHK(got, winner(lfsr[10:0] | 11'h400))
      if (got[6]) `CHK({interruptAckCycle, busLock}, 2'b11)
      finish();
    end
    // Idle bus: control floats one clock before the grant, address/data with it.
    want <= 1'b1;
    for (int i = 0; i < 12 && busFloat.floatCtrl !== 1'b1; i++) tick();
    `CHK({busFloat, busGrantOut}, 3'b100)
    tick();
    `CHK({busFloat, busGrantOut}, 3'b111)
    tick(5);
    `CHK(busGrantOut, 1'b1)
    want <= 1'b0;
    waitGrant(1'b0, 8);
    tick(3);
    `CHK(busFloat.floatCtrl, 1'b1)
    idleOrPowerdown <= 1'b1;
    tick(3);
    `CHK(busFloat, 2'b00)
    idleOrPowerdown <= 1'b0;
    // A cycle stalled on not-ready holds off the grant.
    issue(11'h200);
    want <= 1'b1;
    tick(10);
    `CHK(busGrantOut, 1'b0)
    finish();
    waitGrant(1'b1, 8);
    `CHK(busGrantOut, 1'b1)
    // Refresh while held: grant drops, refresh runs, a new request wins again.
    cycleReq <= 11'h002;
    waitGrant(1'b0, 4);
    `CHK(busGrantOut, 1'b0)
    // The master has rested its request for three clocks and raised it again one clock before refresh starts.
    issue(11'h002);
    `CHK({got, holdRequest}, 12'h005)
    finish();
    waitGrant(1'b1, 12);
    `CHK(busGrantOut, 1'b1)
    want <= 1'b0;
    waitGrant(1'b0, 8);
    // Locked instruction records the hold and grants it afterwards.
    lockedInstr <= 1'b1;
    want <= 1'b1;
    tick(12);
    `CHK(busGrantOut, 1'b0)
    lockedInstr <= 1'b0;
    waitGrant(1'b1, 8);
    `CHK(busGrantOut, 1'b1)
    want <= 1'b0;
    tick(6);
    completeRun();
  end
endmodule : testbench

`default_nettype wire
